// [exr_cpu_exception_detect_record.sv]
// Exception detection and recording unit with its APB register file.
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`include "exr_consts.svh"

module exr_cpu_exception_detect_record #(
  parameter logic [63:0] PRIM_OK   = `EXR_PRIM_OK,
  parameter logic [63:0] FUNC_OK   = `EXR_FUNC_OK,
  parameter logic [31:0] RIMM_OK   = `EXR_RIMM_OK,
  parameter logic [63:0] PRIM_WIDE = `EXR_PRIM_WIDE,
  parameter logic [63:0] FUNC_WIDE = `EXR_FUNC_WIDE
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire exr_pkg::exr_pipe_t pipe,
  input  wire exr_pkg::exr_mem_t mem,
  input  wire logic              bus_fault_fetch,
  input  wire logic              bus_fault_data,
  input  wire logic [5:0]        hw_irq,
  input  wire logic [5:0]        float_cause_set,
  input  wire logic              return_from_handler,
  output logic                   exc_take,
  output logic      [4:0]        exc_code,
  output logic      [31:0]       exc_return_pc,
  output logic                   exc_delay_slot,
  output logic                   cpu_irq
);
  import exr_pkg::*;

  // ========================================================
  // Arithmetic helpers
  function automatic logic wraps(input logic [63:0] a, input logic [63:0] b,
                                 input logic sub, input logic wide);
    logic [63:0] r;
    logic        sa;
    logic        sb;
    logic        sr;
    r  = sub ? a - b : a + b;
    sa = wide ? a[63] : a[31];
    sb = wide ? b[63] : b[31];
    sr = wide ? r[63] : r[31];
    wraps = sub ? ((sa != sb) && (sr != sa)) : ((sa == sb) && (sr != sa));
  endfunction

  function automatic logic trap_true(input logic [63:0] a,
                                     input logic [63:0] b,
                                     input logic [2:0]  sel);
    case (sel)
      3'h0:    trap_true = $signed(a) >= $signed(b);
      3'h1:    trap_true = a >= b;
      3'h2:    trap_true = $signed(a) < $signed(b);
      3'h3:    trap_true = a < b;
      3'h4:    trap_true = a == b;
      default: trap_true = a != b;
    endcase
  endfunction

  exr_state_t  s;
  exr_state_t  next_s;
  logic [5:0]  opc;
  logic [5:0]  fn;
  logic [4:0]  rt;
  logic [63:0] imm;
  logic        kernel;
  logic        hit_cop;
  logic        hit_rsvd;
  logic        hit_kcall;
  logic        hit_brk;
  logic        hit_wrap;
  logic        hit_check;
  logic        hit_float;
  logic        hit_watch;
  logic        hit_int;
  logic        watch_match;
  logic        irq_now;
  logic [7:0]  pending;
  logic [1:0]  cop_sel;
  logic        is_cop;
  logic        is_wide;
  logic [31:0] rd_word;
  logic        rd_ok;
  logic        wr_now;

  // ========================================================
  // Decode; the breakpoint payload is never looked at.
  assign opc    = pipe.instr[31:26];
  assign fn     = pipe.instr[5:0];
  assign rt     = pipe.instr[20:16];
  assign imm    = {{48{pipe.instr[15]}}, pipe.instr[15:0]};
  assign kernel = (s.mode == `EXR_MODE_KERNEL) || s.exception_level_flag;
  assign is_cop = (opc[5:2] == `EXR_OP_COPZ_HI) ||
                  ((opc[5:4] == `EXR_OP_COPLS_HI) && (^opc[1:0]));
  assign cop_sel = opc[1:0];
  // Kernel mode runs wide ops whatever the kernel wide flag says.
  assign is_wide = PRIM_WIDE[opc] ||
                   ((opc == `EXR_OP_FUNC) && FUNC_WIDE[fn]);

  always_comb begin
    hit_cop   = 1'b0;
    hit_rsvd  = 1'b0;
    hit_kcall = 1'b0;
    hit_brk   = 1'b0;
    hit_wrap  = 1'b0;
    hit_check = 1'b0;
    if (pipe.valid) begin
      hit_cop = is_cop && !s.cop_usable[cop_sel] &&
                !((cop_sel == 2'h0) && kernel);
      hit_rsvd = !PRIM_OK[opc] ||
                 ((opc == `EXR_OP_FUNC) && !FUNC_OK[fn]) ||
                 ((opc == `EXR_OP_RIMM) && !RIMM_OK[rt]) ||
                 (is_wide && !kernel && !s.wide_ok);
      if (opc == `EXR_OP_FUNC) begin
        hit_kcall = fn == `EXR_FN_KCALL;
        hit_brk   = fn == `EXR_FN_BRKPT;
        hit_wrap  = ((fn == `EXR_FN_SUM) || (fn == `EXR_FN_WSUM) ||
                     (fn == `EXR_FN_DIFF) || (fn == `EXR_FN_WDIFF)) &&
                    wraps(pipe.op_a, pipe.op_b, fn[1],
                          fn == `EXR_FN_WSUM || fn == `EXR_FN_WDIFF);
        hit_check = (fn[5:3] == `EXR_FN_TRAP_HI) && FUNC_OK[fn] &&
                    trap_true(pipe.op_a, pipe.op_b, fn[2:0]);
      end else if (opc == `EXR_OP_RIMM) begin
        hit_check = (rt[4:3] == `EXR_RT_TRAP_HI) && RIMM_OK[rt] &&
                    trap_true(pipe.op_a, imm, rt[2:0]);
      end else begin
        hit_wrap = ((opc == `EXR_OP_SUM_IMM) ||
                    (opc == `EXR_OP_WSUM_IMM)) &&
                   wraps(pipe.op_a, imm, 1'b0,
                         opc == `EXR_OP_WSUM_IMM);
      end
    end
  end

  // ========================================================
  // Watch, float and interrupt conditions
  assign watch_match = mem.valid && !mem.cache_op &&
    (mem.paddr[35:`EXR_MATCH_ADDR_LO] ==
     {s.addr_match_high_reg,
      s.addr_match_low_reg[31:`EXR_MATCH_ADDR_LO]}) &&
    ((mem.load && s.addr_match_low_reg[`EXR_MATCH_LOAD]) ||
     (mem.store && s.addr_match_low_reg[`EXR_MATCH_STORE]));
  assign pending   = {s.hw_live, s.soft_irq};
  assign irq_now   = s.global_irq_enable && |(pending & s.irq_mask);
  assign hit_float = pipe.valid && !s.exception_level_flag &&
                     (|s.float_cause);
  assign hit_watch = pipe.valid && !s.exception_level_flag &&
                     s.watch_pend;
  assign hit_int   = pipe.valid && !s.exception_level_flag && irq_now;

  // ========================================================
  // Register read mux
  always_comb begin
    rd_word = 32'h00000000;
    rd_ok   = 1'b1;
    unique case (paddr)
      `EXR_STATUS_OFF: begin
        rd_word[`EXR_ST_GIE]   = s.global_irq_enable;
        rd_word[`EXR_ST_LEVEL] = s.exception_level_flag;
        rd_word[`EXR_ST_MODE_HI:`EXR_ST_MODE_LO] = s.mode;
        rd_word[`EXR_ST_WIDE_OK] = s.wide_ok;
        rd_word[`EXR_ST_KWIDE]   = s.kernel_wide_addr_flag;
        rd_word[`EXR_ST_MASK_HI:`EXR_ST_MASK_LO] = s.irq_mask;
        rd_word[`EXR_ST_CU_HI:`EXR_ST_CU_LO]     = s.cop_usable;
      end
      `EXR_CAUSE_OFF: begin
        rd_word[`EXR_CA_CODE_HI:`EXR_CA_CODE_LO] = s.cause_code_field;
        rd_word[`EXR_CA_SOFT_HI:`EXR_CA_SOFT_LO] = s.soft_irq;
        rd_word[`EXR_CA_HW_HI:`EXR_CA_HW_LO]     = s.hw_live;
        rd_word[`EXR_CA_COP_HI:`EXR_CA_COP_LO]   = s.cop_num;
        rd_word[`EXR_CA_SLOT] = s.delay_slot_flag;
      end
      `EXR_RETPC_OFF:    rd_word = s.return_pc_reg;
      `EXR_MATCH_LO_OFF: rd_word = s.addr_match_low_reg;
      `EXR_MATCH_HI_OFF: rd_word[3:0] = s.addr_match_high_reg;
      `EXR_FCSR_OFF:     rd_word[`EXR_FCSR_HI:`EXR_FCSR_LO] = s.float_cause;
      default:           rd_ok = 1'b0;
    endcase
  end

  assign wr_now = psel && penable && s.pready && pwrite && rd_ok;

  // ========================================================
  // Next state
  always_comb begin
    next_s = s;
    // Pins pass three flops; a change counts once the last two agree.
    next_s.hw_s1 = hw_irq;
    next_s.hw_s2 = s.hw_s1;
    next_s.hw_s3 = s.hw_s2;
    next_s.be_s1 = {bus_fault_data, bus_fault_fetch};
    next_s.be_s2 = s.be_s1;
    next_s.be_s3 = s.be_s2;
    for (int i = 0; i < 6; i++) begin
      if (s.hw_s2[i] == s.hw_s3[i]) begin
        next_s.hw_live[i] = s.hw_s3[i];
      end
    end
    for (int i = 0; i < 2; i++) begin
      if (s.be_s2[i] == s.be_s3[i]) begin
        next_s.be_live[i] = s.be_s3[i];
      end
    end

    // APB: one wait state, then the answer stands for one cycle.
    next_s.pready  = psel && penable && !s.pready;
    next_s.pslverr = psel && penable && !s.pready && !rd_ok;
    next_s.prdata  = (psel && penable && !s.pready && !pwrite) ?
                     rd_word : 32'h00000000;
    if (wr_now) begin
      unique case (paddr)
        `EXR_STATUS_OFF: begin
          next_s.global_irq_enable     = pwdata[`EXR_ST_GIE];
          next_s.exception_level_flag  = pwdata[`EXR_ST_LEVEL];
          next_s.mode    = pwdata[`EXR_ST_MODE_HI:`EXR_ST_MODE_LO];
          next_s.wide_ok = pwdata[`EXR_ST_WIDE_OK];
          next_s.kernel_wide_addr_flag = pwdata[`EXR_ST_KWIDE];
          next_s.irq_mask   = pwdata[`EXR_ST_MASK_HI:`EXR_ST_MASK_LO];
          next_s.cop_usable = pwdata[`EXR_ST_CU_HI:`EXR_ST_CU_LO];
        end
        `EXR_CAUSE_OFF:
          next_s.soft_irq = pwdata[`EXR_CA_SOFT_HI:`EXR_CA_SOFT_LO];
        `EXR_RETPC_OFF:    next_s.return_pc_reg = pwdata;
        `EXR_MATCH_LO_OFF: next_s.addr_match_low_reg = pwdata;
        `EXR_MATCH_HI_OFF: next_s.addr_match_high_reg = pwdata[3:0];
        `EXR_FCSR_OFF:
          next_s.float_cause = pwdata[`EXR_FCSR_HI:`EXR_FCSR_LO];
        default: ;
      endcase
    end
    // Hardware sets win over a software clear in the same cycle.
    next_s.float_cause = next_s.float_cause | float_cause_set;
    next_s.be_pend = s.be_pend | (next_s.be_live & ~s.be_live);
    next_s.watch_pend = s.watch_pend | watch_match;
    if (return_from_handler) begin
      next_s.exception_level_flag = 1'b0;
    end

    // Only the top condition is recorded; lower bus fault, watch, float and interrupt requests stay pending, the others are dropped.
    next_s.take      = 1'b0;
    next_s.take_code = s.take_code;
    if (pipe.valid && s.be_pend[0]) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_FETCH_BUS_CODE;
      next_s.be_pend[0] = next_s.be_live[0] & ~s.be_live[0];
    end else if (pipe.valid && s.be_pend[1]) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_DATA_BUS_CODE;
      next_s.be_pend[1] = next_s.be_live[1] & ~s.be_live[1];
    end else if (hit_cop) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_COP_CODE;
      next_s.cop_num   = cop_sel;
    end else if (hit_rsvd) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_RSVD_CODE;
    end else if (hit_kcall || hit_brk) begin
      next_s.take      = 1'b1;
      next_s.take_code = hit_kcall ? `EXR_KCALL_CODE : `EXR_BRKPT_CODE;
    end else if (hit_wrap) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_WRAP_CODE;
    end else if (hit_check) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_CHECK_CODE;
    end else if (hit_float) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_FLOAT_CODE;
    end else if (hit_watch) begin
      next_s.take       = 1'b1;
      next_s.take_code  = `EXR_WATCH_CODE;
      next_s.watch_pend = watch_match;
    end else if (hit_int) begin
      next_s.take      = 1'b1;
      next_s.take_code = `EXR_INT_CODE;
    end
    if (next_s.take) begin
      next_s.cause_code_field = next_s.take_code;
      // A nested exception keeps the outer return point.
      if (!s.exception_level_flag) begin
        next_s.return_pc_reg   = pipe.in_slot ? pipe.branch_pc
                                              : pipe.pc;
        next_s.delay_slot_flag = pipe.in_slot;
      end
      next_s.exception_level_flag = 1'b1;
    end
    next_s.irq = irq_now;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else if (clk_en) begin
      s <= next_s;
    end
  end

  assign prdata         = s.prdata;
  assign pready         = s.pready;
  assign pslverr        = s.pslverr;
  assign exc_take       = s.take;
  assign exc_code       = s.take_code;
  assign exc_return_pc  = s.return_pc_reg;
  assign exc_delay_slot = s.delay_slot_flag;
  assign cpu_irq        = s.irq;

  // ========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence taken_with(logic [4:0] c);
    ##1 (s.take && s.take_code == c);
  endsequence

  sequence no_higher;
    clk_en && pipe.valid && s.be_pend == 2'h0 && !hit_cop;
  endsequence

  irq_gate_a: assert property (clk_en |=> cpu_irq == $past(irq_now))
    else $error("cpu_irq does not follow masked request");
  bus_code_a: assert property (
    clk_en && pipe.valid && s.be_pend[0]
    |-> taken_with(`EXR_FETCH_BUS_CODE))
    else $error("fetch bus fault not recorded");
  rsvd_code_a: assert property (no_higher and hit_rsvd
    |-> taken_with(`EXR_RSVD_CODE))
    else $error("reserved opcode not recorded");
  wrap_code_a: assert property (
    no_higher and (!hit_rsvd && !hit_kcall && !hit_brk && hit_wrap)
    |-> taken_with(`EXR_WRAP_CODE))
    else $error("arithmetic wrap not recorded");
  cop_num_a: assert property (
    clk_en && pipe.valid && s.be_pend == 2'h0 && hit_cop
    |=> s.take_code == `EXR_COP_CODE && s.cop_num == $past(cop_sel))
    else $error("coprocessor number not recorded");
  slot_pc_a: assert property (
    clk_en && !s.exception_level_flag && next_s.take && pipe.in_slot
    |=> exc_return_pc == $past(pipe.branch_pc) && exc_delay_slot)
    else $error("delay slot return pc wrong");
  float_hold_a: assert property (
    clk_en && (|s.float_cause) && !(wr_now && paddr == `EXR_FCSR_OFF)
    |=> (|s.float_cause))
    else $error("float condition dropped without clear");
  watch_wait_a: assert property (
    clk_en && s.watch_pend && s.exception_level_flag && !return_from_handler
    |=> s.watch_pend && !(s.take && s.take_code == `EXR_WATCH_CODE))
    else $error("watch taken while level flag set");
  soft_clear_a: assert property (
    clk_en && wr_now && paddr == `EXR_CAUSE_OFF
    |=> s.soft_irq == $past(pwdata[`EXR_CA_SOFT_HI:`EXR_CA_SOFT_LO]))
    else $error("soft line write lost");
  apb_wait_a: assert property (clk_en && psel && penable && !pready
    |=> pready ##1 !pready)
    else $error("apb answer timing wrong");
endmodule

// [exr_consts.svh]
// Offsets, field positions, codes and decode masks of the exception unit.
`ifndef EXR_CONSTS_SVH
`define EXR_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define EXR_STATUS_OFF     8'h00
`define EXR_CAUSE_OFF      8'h04
`define EXR_RETPC_OFF      8'h08
`define EXR_MATCH_LO_OFF   8'h0C
`define EXR_MATCH_HI_OFF   8'h10
`define EXR_FCSR_OFF       8'h14

// ==========================================================
// Status field positions
`define EXR_ST_GIE         0
`define EXR_ST_LEVEL       1
`define EXR_ST_MODE_LO     3
`define EXR_ST_MODE_HI     4
`define EXR_ST_WIDE_OK     5
`define EXR_ST_KWIDE       7
`define EXR_ST_MASK_LO     8
`define EXR_ST_MASK_HI     15
`define EXR_ST_CU_LO       28
`define EXR_ST_CU_HI       31

// ==========================================================
// Cause, float status and match field positions
`define EXR_CA_CODE_LO     2
`define EXR_CA_CODE_HI     6
`define EXR_CA_SOFT_LO     8
`define EXR_CA_SOFT_HI     9
`define EXR_CA_HW_LO       10
`define EXR_CA_HW_HI       15
`define EXR_CA_COP_LO      28
`define EXR_CA_COP_HI      29
`define EXR_CA_SLOT        31
`define EXR_FCSR_LO        12
`define EXR_FCSR_HI        17
`define EXR_MATCH_LOAD     1
`define EXR_MATCH_STORE    0
`define EXR_MATCH_ADDR_LO  3

// ==========================================================
// Cause codes
`define EXR_INT_CODE       5'h00
`define EXR_FETCH_BUS_CODE 5'h06
`define EXR_DATA_BUS_CODE  5'h07
`define EXR_KCALL_CODE     5'h08
`define EXR_BRKPT_CODE     5'h09
`define EXR_RSVD_CODE      5'h0A
`define EXR_COP_CODE       5'h0B
`define EXR_WRAP_CODE      5'h0C
`define EXR_CHECK_CODE     5'h0D
`define EXR_FLOAT_CODE     5'h0F
`define EXR_WATCH_CODE     5'h17

// ==========================================================
// Instruction decode
`define EXR_OP_FUNC        6'h00
`define EXR_OP_RIMM        6'h01
`define EXR_OP_SUM_IMM     6'h08
`define EXR_OP_WSUM_IMM    6'h18
`define EXR_OP_COPZ_HI     4'h4
`define EXR_OP_COPLS_HI    2'h3
`define EXR_FN_SUM         6'h20
`define EXR_FN_DIFF        6'h22
`define EXR_FN_WSUM        6'h2C
`define EXR_FN_WDIFF       6'h2E
`define EXR_FN_KCALL       6'h0C
`define EXR_FN_BRKPT       6'h0D
`define EXR_FN_TRAP_HI     3'h6
`define EXR_RT_TRAP_HI     2'h1
`define EXR_MODE_KERNEL    2'h0
`define EXR_PRIM_OK        64'hF7FFFFFF0FFFFFFF
`define EXR_FUNC_OK        64'hDD5FFCFFFFDFBFDF
`define EXR_RIMM_OK        32'h000F5F0F
`define EXR_PRIM_WIDE      64'h909030000F000000
`define EXR_FUNC_WIDE      64'hDD00F000F0D00000

`endif

// [exr_pkg.sv]
// Types shared by the exception unit and its neighbours.
package exr_pkg;

  // ========================================================
  // Carriers
  typedef struct packed {
    logic        valid;
    logic [31:0] instr;
    logic [31:0] pc;
    logic        in_slot;
    logic [31:0] branch_pc;
    logic [63:0] op_a;
    logic [63:0] op_b;
  } exr_pipe_t;

  typedef struct packed {
    logic        valid;
    logic        load;
    logic        store;
    logic        cache_op;
    logic [35:0] paddr;
  } exr_mem_t;

  // ========================================================
  // Whole state of the unit
  typedef struct packed {
    logic        global_irq_enable;
    logic        exception_level_flag;
    logic [1:0]  mode;
    logic        wide_ok;
    logic        kernel_wide_addr_flag;
    logic [7:0]  irq_mask;
    logic [3:0]  cop_usable;
    logic [4:0]  cause_code_field;
    logic        delay_slot_flag;
    logic [1:0]  cop_num;
    logic [1:0]  soft_irq;
    logic [5:0]  hw_live;
    logic [31:0] return_pc_reg;
    logic [31:0] addr_match_low_reg;
    logic [3:0]  addr_match_high_reg;
    logic [5:0]  float_cause;
    logic [5:0]  hw_s1;
    logic [5:0]  hw_s2;
    logic [5:0]  hw_s3;
    logic [1:0]  be_s1;
    logic [1:0]  be_s2;
    logic [1:0]  be_s3;
    logic [1:0]  be_live;
    logic [1:0]  be_pend;
    logic        watch_pend;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        take;
    logic [4:0]  take_code;
    logic        irq;
  } exr_state_t;

endpackage

// [exr_board_model.sv]
// Board model: bus failure pins and interrupt request lines.
`timescale 1ns/1ps
module exr_board_model (
  input  wire logic       pclk,
  input  wire logic [1:0] fault_cmd,
  input  wire logic [5:0] irq_cmd,
  output logic            bus_fault_fetch,
  output logic            bus_fault_data,
  output logic [5:0]      hw_irq
);
  // ==========================================================
  // Pins
  // A fault stays one extra cycle so a slow synchroniser cannot miss it.
  logic [1:0] hold = 2'h0;
  always_ff @(posedge pclk) begin
    hold <= fault_cmd;
  end
  assign bus_fault_fetch = fault_cmd[0] | hold[0];
  assign bus_fault_data  = fault_cmd[1] | hold[1];
  assign hw_irq          = irq_cmd;
endmodule

// [exr_cpu_exception_detect_record_tb_top.sv]
// Self-checking bench of the exception unit.
`timescale 1ns/1ps
`include "exr_consts.svh"
module exr_cpu_exception_detect_record_tb_top;
  import exr_pkg::*;
  // ==========================================================
  // Signals
  logic        pclk = 1'b0, presetn = 1'b0, rfh = 1'b0, ce = 1'b1, err;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rpc, rd;
  logic        pready, pslverr, bff, bfd, take, dslot, cpu_irq;
  exr_pipe_t   pipe = '0;
  exr_mem_t    mem = '0;
  logic [1:0]  fault_cmd = 2'h0;
  logic [5:0]  irq_cmd = 6'h00, fset = 6'h00, hw_irq;
  logic [4:0]  code;
  int          miscompares = 0, tests_run = 0;
  always #25 pclk = ~pclk;
  exr_cpu_exception_detect_record u_exr_cpu_exception_detect_record (
    .pclk(pclk), .presetn(presetn), .clk_en(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pipe(pipe),
    .mem(mem), .bus_fault_fetch(bff), .bus_fault_data(bfd),
    .hw_irq(hw_irq), .float_cause_set(fset), .return_from_handler(rfh),
    .exc_take(take), .exc_code(code), .exc_return_pc(rpc),
    .exc_delay_slot(dslot), .cpu_irq(cpu_irq));
  exr_board_model u_exr_board_model (
    .pclk(pclk), .fault_cmd(fault_cmd), .irq_cmd(irq_cmd),
    .bus_fault_fetch(bff), .bus_fault_data(bfd), .hw_irq(hw_irq));
  // ==========================================================
  // Tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [31:0] ins, input logic [63:0] x,
                     input logic [63:0] y, input logic slot,
                     input logic [4:0] exp);
    logic [31:0] pcv;
    pcv = $urandom & 32'hFFFFFFFC;
    rfh <= 1'b1;
    @(posedge pclk);
    rfh <= 1'b0;
    pipe <= '{1'b1, ins, pcv, slot, pcv - 32'h4, x, y};
    @(posedge pclk);
    pipe.valid <= 1'b0;
    do begin
      @(posedge pclk);
    end while (take !== 1'b1);
    chk({27'h0, code}, {27'h0, exp});
    chk(rpc, slot ? pcv - 32'h4 : pcv);
    chk({31'h0, dslot}, {31'h0, slot});
  endtask
  task automatic final_report;
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    final_report;
  end
  // ==========================================================
  // Scenarios
  initial begin
    logic [31:0] a;
    int ln;
    void'($urandom(32'h3C49));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `EXR_STATUS_OFF, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({err, rd[30:0]}, 32'h8000_0000);
    a = $urandom;
    run({26'h0, `EXR_FN_KCALL}, '0, '0, a[0], `EXR_KCALL_CODE);
    // A frozen unit must neither take nor record anything.
    ce <= 1'b0;
    pipe <= '{1'b1, {26'h0, `EXR_FN_KCALL}, a, 1'b0, a, 64'h0, 64'h0};
    repeat (3) @(posedge pclk);
    chk({31'h0, take}, 32'h0);
    chk({27'h0, code}, {27'h0, `EXR_KCALL_CODE});
    pipe.valid <= 1'b0;
    ce <= 1'b1;
    run({6'h00, a[19:0], `EXR_FN_BRKPT}, '0, '0, 1'b1, `EXR_BRKPT_CODE);
    run({6'h1C, 26'h0}, '0, '0, a[20], `EXR_RSVD_CODE);
    a = (a & 32'h7FFF_FFFF) | 32'h4000_0000;
    run({26'h0, `EXR_FN_SUM}, {32'h0, a}, 64'h4000_0000, 1'b0, `EXR_WRAP_CODE);
    run({26'h0, `EXR_FN_WSUM}, {32'h7FFF_FFFF, a}, {a, a}, 1'b0, `EXR_WRAP_CODE);
    run({26'h0, `EXR_FN_WDIFF}, {1'b1, 63'h0}, 64'h1, 1'b1, `EXR_WRAP_CODE);
    run({26'h0, 6'h34}, {32'h0, a}, {32'h0, a}, 1'b0, `EXR_CHECK_CODE);
    run({26'h0, 6'h36}, {32'h0, a}, {32'h0, ~a}, 1'b1, `EXR_CHECK_CODE);
    fault_cmd <= 2'b01;
    repeat (6) @(posedge pclk);
    fault_cmd <= 2'b00;
    run({6'h1C, 26'h0}, '0, '0, 1'b0, `EXR_FETCH_BUS_CODE);
    fault_cmd <= 2'b10;
    repeat (6) @(posedge pclk);
    fault_cmd <= 2'b00;
    run(32'h0, '0, '0, 1'b1, `EXR_DATA_BUS_CODE);
    apb(1'b1, `EXR_STATUS_OFF, 32'h0000_0010);
    run({6'h11, 26'h0}, '0, '0, 1'b0, `EXR_COP_CODE);
    apb(1'b0, `EXR_CAUSE_OFF, 32'h0);
    chk(rd & 32'h3000_0000, 32'h1000_0000);
    apb(1'b1, `EXR_STATUS_OFF, 32'h0);
    fset <= 6'h04;
    @(posedge pclk);
    fset <= 6'h00;
    run(32'h0, '0, '0, 1'b0, `EXR_FLOAT_CODE);
    run(32'h0, '0, '0, 1'b0, `EXR_FLOAT_CODE);
    apb(1'b1, `EXR_FCSR_OFF, 32'h0);
    apb(1'b1, `EXR_MATCH_LO_OFF, {a[31:3], 3'h2});
    apb(1'b1, `EXR_MATCH_HI_OFF, 32'h0);
    // One matching load only: a match in the take cycle would re-arm watch.
    mem <= '{1'b1, 1'b1, 1'b0, 1'b0, {4'h0, a[31:3], 3'h0}};
    @(posedge pclk);
    mem <= '0;
    @(posedge pclk);
    run(32'h0, '0, '0, 1'b0, `EXR_WATCH_CODE);
    ln = $urandom_range(5, 0);
    irq_cmd <= 6'h01 << ln;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, `EXR_STATUS_OFF, ({31'h0, k[1]} << (10 + ln)) | k[0]);
      repeat (4) @(posedge pclk);
      chk({31'h0, cpu_irq}, {31'h0, k == 3});
    end
    apb(1'b0, `EXR_CAUSE_OFF, 32'h0);
    chk(rd & 32'h0000_FF00, 32'h400 << ln);
    run(32'h0, '0, '0, 1'b0, `EXR_INT_CODE);
    irq_cmd <= 6'h00;
    repeat (6) @(posedge pclk);
    apb(1'b0, `EXR_CAUSE_OFF, 32'h0);
    chk(rd & 32'h0000_FF00, 32'h0);
    apb(1'b1, `EXR_CAUSE_OFF, 32'h300);
    apb(1'b0, `EXR_CAUSE_OFF, 32'h0);
    chk(rd & 32'h0000_FF00, 32'h300);
    apb(1'b1, `EXR_CAUSE_OFF, 32'h0);
    apb(1'b0, `EXR_CAUSE_OFF, 32'h0);
    chk(rd & 32'h0000_FF00, 32'h0);
    final_report;
  end
endmodule
